/* common/sltc_pkg.sv */
// Constants and types for the standby load transfer control block
package sltc_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_HZ = 1_000;
  localparam int TICK_DIV = CLK_HZ / TICK_HZ;
  localparam int OPEN_ATTEMPTS = 3;
  localparam int ATTEMPT_MS = 200;
  localparam int MS_W = 16;
  localparam int PWR_W = 16;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_MAN = 2'h1;
  localparam logic [1:0] MODE_AUTO = 2'h2;
  localparam logic [1:0] MODE_TEST = 2'h3;
  typedef enum logic [4:0] {
    XS_MAINS = 5'b00001,
    XS_OPEN_MAINS = 5'b00010,
    XS_GEN = 5'b00100,
    XS_DROP = 5'b01000,
    XS_WAIT_BACK = 5'b10000
  } sltc_xfer_e;
endpackage : sltc_pkg

/* common/sltc_tmr_if.sv */
// Interface between the transfer sequencer and the exchange timer
`timescale 1ns/100ps
interface sltc_tmr_if;
  logic load;
  logic [sltc_pkg::MS_W-1:0] count_ms;
  logic tick;
  logic done;
  modport ctrl (output load, output count_ms, input tick, input done);
  modport tmr (input load, input count_ms, output tick, output done);
endinterface : sltc_tmr_if

/* core/sltc_core.sv */
// Breaker permission and users transfer control for one standby generator controller
`timescale 1ns/100ps
module sltc_core #(
  parameter int DIV = sltc_pkg::TICK_DIV,
  parameter int ATTEMPT_MS = sltc_pkg::ATTEMPT_MS
) (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  // Breaker status
  input wire logic GEN_BRK_CLOSED_I,
  input wire logic MAINS_BRK_CLOSED_I,
  input wire logic LTB_BRK_CLOSED_I,
  input wire logic LTB_BRK_PRESENT_I,
  // Mode and settings
  input wire logic [1:0] MODE_I,
  input wire logic REMOTE_RUN_I,
  input wire logic KEEP_SUPPLY_I,
  input wire logic TEST_LOAD_I,
  input wire logic GTS_ASSIGNED_I,
  input wire logic MTS_ASSIGNED_I,
  input wire logic [sltc_pkg::MS_W-1:0] EXCHANGE_MS_I,
  input wire logic [sltc_pkg::MS_W-1:0] MAINS_DELAY_MS_I,
  // Conditions
  input wire logic MAINS_IN_TOL_I,
  input wire logic INHIBIT_CONTACT_FAIL_I,
  input wire logic START_INHIBIT_I,
  input wire logic LOAD_INHIBIT_I,
  input wire logic SHUTDOWN_I,
  input wire logic ENGINE_RUNNING_I,
  input wire logic ANY_GEN_RUNNING_I,
  input wire logic WARN_ACK_I,
  input wire logic IMMEDIATE_SUPPLY_I,
  // Coordination bus data
  input wire logic [sltc_pkg::PWR_W-1:0] CLOSED_RATED_PWR_I,
  input wire logic NO_OPEN_AVAIL_I,
  input wire logic [sltc_pkg::PWR_W-1:0] DEMAND_LOCAL_I,
  input wire logic DEMAND_LOCAL_WR_I,
  input wire logic [sltc_pkg::PWR_W-1:0] DEMAND_BUS_I,
  input wire logic DEMAND_BUS_WR_I,
  // Outputs
  output logic [sltc_pkg::PWR_W-1:0] DEMAND_O,
  output logic DEMAND_BUS_SEND_O,
  output logic START_REQ_O,
  output logic INTERVENTION_REQ_O,
  output logic GEN_BRK_CLOSE_O,
  output logic BREAKER_OPEN_FAIL_WARNING_O,
  output logic BARS_SWITCH_CLOSE_O,
  output logic MAINS_SWITCH_OPEN_O,
  output logic AUTO_FORCED_O
);
  localparam logic [1:0] ATT_MAX = 2'(sltc_pkg::OPEN_ATTEMPTS);

  // Input synchroniser stage, one bank for the 20 breaker, mode, flag and condition bits
  localparam int NS = 20;
  wire [NS-1:0] raw = {GEN_BRK_CLOSED_I, MAINS_BRK_CLOSED_I, LTB_BRK_CLOSED_I, LTB_BRK_PRESENT_I,
    MODE_I, REMOTE_RUN_I, KEEP_SUPPLY_I, TEST_LOAD_I, GTS_ASSIGNED_I, MTS_ASSIGNED_I,
    MAINS_IN_TOL_I, INHIBIT_CONTACT_FAIL_I, START_INHIBIT_I, LOAD_INHIBIT_I, SHUTDOWN_I,
    ENGINE_RUNNING_I, ANY_GEN_RUNNING_I, WARN_ACK_I, IMMEDIATE_SUPPLY_I};
  // Mains reads in tolerance during reset, so no false tolerance edge follows release
  localparam logic [NS-1:0] SYNC_RST = 20'h0_0100;
  logic [NS-1:0] s1_reg, s2_reg;
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s1_reg <= SYNC_RST;
      s2_reg <= SYNC_RST;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
    end
  end
  wire gb_closed = s2_reg[19];
  wire mb_closed = s2_reg[18];
  wire lb_closed = s2_reg[17];
  wire lb_present = s2_reg[16];
  wire [1:0] mode = s2_reg[15:14];
  wire remote_run = s2_reg[13];
  wire keep_supply = s2_reg[12];
  wire test_load = s2_reg[11];
  wire gts_assigned = s2_reg[10];
  wire mts_assigned = s2_reg[9];
  wire mains_ok = s2_reg[8];
  wire inh_fail = s2_reg[7];
  wire start_inh = s2_reg[6];
  wire load_inh = s2_reg[5];
  wire shutdown = s2_reg[4];
  wire engine_run = s2_reg[3];
  wire any_run = s2_reg[2];
  wire warn_ack = s2_reg[1];
  wire immediate = s2_reg[0];

  // Shared exchange timer
  sltc_tmr_if tif ();
  sltc_timer #(.DIV(DIV)) u_timer (.clk_i(CLK_SYS_I), .rst_n_i(RST_N_I), .tmr(tif));

  // Mains tolerance persistence, counted in millisecond ticks
  logic [sltc_pkg::MS_W-1:0] tol_cnt_reg;
  logic tol_last_reg;
  logic start_req_reg;
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      tol_cnt_reg <= '0;
      tol_last_reg <= 1'b1;
      start_req_reg <= 1'b0;
    end else begin
      tol_last_reg <= mains_ok;
      if (mains_ok != tol_last_reg) tol_cnt_reg <= '0;
      else if (tif.tick && tol_cnt_reg < MAINS_DELAY_MS_I) tol_cnt_reg <= tol_cnt_reg + 1'b1;
      if (mains_ok == tol_last_reg && tol_cnt_reg >= MAINS_DELAY_MS_I)
        start_req_reg <= !mains_ok;
    end
  end
  assign START_REQ_O = start_req_reg;

  // Mode decode: a mains or contact failure in test turns the mode to automatic
  wire trouble = start_req_reg || inh_fail;
  logic forced_auto_reg;
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) forced_auto_reg <= 1'b0;
    else if (mode != sltc_pkg::MODE_TEST) forced_auto_reg <= 1'b0;
    else if (trouble) forced_auto_reg <= 1'b1;
  end
  wire is_auto = (mode == sltc_pkg::MODE_AUTO) || forced_auto_reg;
  wire is_test = (mode == sltc_pkg::MODE_TEST) && !forced_auto_reg;
  assign AUTO_FORCED_O = forced_auto_reg;

  // Breaker open-failure tracking, three attempts at fixed spacing
  wire mains_parallel = mb_closed && (lb_closed || !lb_present);
  logic [1:0] att_reg;
  logic [sltc_pkg::MS_W-1:0] att_ms_reg;
  logic warn_reg;
  wire gen_close;
  wire want_open = !gen_close && gb_closed;
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      att_reg <= '0;
      att_ms_reg <= '0;
      warn_reg <= 1'b0;
    end else begin
      if (!want_open) begin
        att_reg <= '0;
        att_ms_reg <= '0;
      end else if (tif.tick) begin
        if (att_ms_reg == sltc_pkg::MS_W'(ATTEMPT_MS - 1)) begin
          att_ms_reg <= '0;
          if (att_reg != ATT_MAX) att_reg <= att_reg + 2'h1;
        end else att_ms_reg <= att_ms_reg + 1'b1;
      end
      // Setting wins over an acknowledge in the same cycle
      if (want_open && att_reg == ATT_MAX) warn_reg <= 1'b1;
      else if (warn_ack) warn_reg <= 1'b0;
    end
  end
  assign BREAKER_OPEN_FAIL_WARNING_O = warn_reg;

  // Intervention request by mode or remote run, plus keep-supplying on a stuck breaker
  wire keep_req = keep_supply && warn_reg && !shutdown;
  wire intervene = (mode == sltc_pkg::MODE_AUTO && !start_inh && start_req_reg)
    || is_test || forced_auto_reg || remote_run
    || keep_req;
  assign INTERVENTION_REQ_O = intervene;

  // Generator breaker close permission
  wire stop_req = !intervene;
  assign gen_close = engine_run && !shutdown && !stop_req && !load_inh && !(is_test && !test_load)
    && !mains_parallel;
  assign GEN_BRK_CLOSE_O = gen_close;

  // Load demand setting shared over the coordination bus
  logic [sltc_pkg::PWR_W-1:0] demand_reg;
  logic send_reg;
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      demand_reg <= '0;
      send_reg <= 1'b0;
    end else begin
      send_reg <= DEMAND_LOCAL_WR_I;
      if (DEMAND_LOCAL_WR_I) demand_reg <= DEMAND_LOCAL_I;
      else if (DEMAND_BUS_WR_I) demand_reg <= DEMAND_BUS_I;
    end
  end
  assign DEMAND_O = demand_reg;
  assign DEMAND_BUS_SEND_O = send_reg;

  // Transfer decision
  wire xfer_mode = is_auto || (remote_run && trouble);
  wire enough = immediate ? gb_closed
    : (gb_closed && (CLOSED_RATED_PWR_I > demand_reg || NO_OPEN_AVAIL_I));
  wire go_gen = gts_assigned && xfer_mode && enough && !mains_parallel;
  wire leave = !go_gen || !any_run;

  // Transfer sequencer; no switch failure warning exists
  sltc_pkg::sltc_xfer_e st_reg, st_next;
  logic tmr_load;
  always_comb begin
    st_next = st_reg;
    tmr_load = 1'b0;
    unique case (st_reg)
      sltc_pkg::XS_MAINS: if (go_gen) begin
        st_next = mts_assigned ? sltc_pkg::XS_OPEN_MAINS : sltc_pkg::XS_GEN;
        tmr_load = 1'b1;
      end
      sltc_pkg::XS_OPEN_MAINS: if (leave) st_next = sltc_pkg::XS_MAINS;
        else if (tif.done) st_next = sltc_pkg::XS_GEN;
      sltc_pkg::XS_GEN: if (leave) st_next = sltc_pkg::XS_DROP;
      sltc_pkg::XS_DROP: if (!gb_closed || !any_run) begin
        st_next = mts_assigned ? sltc_pkg::XS_WAIT_BACK : sltc_pkg::XS_MAINS;
        tmr_load = 1'b1;
      end
      sltc_pkg::XS_WAIT_BACK: if (tif.done) st_next = sltc_pkg::XS_MAINS;
      default: st_next = sltc_pkg::XS_MAINS;
    endcase
  end
  assign tif.load = tmr_load;
  assign tif.count_ms = EXCHANGE_MS_I;

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) st_reg <= sltc_pkg::XS_MAINS;
    else st_reg <= st_next;
  end

  // Switch outputs from flops; parallel wiring of peers is external
  logic bars_reg, mains_open_reg;
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      bars_reg <= 1'b0;
      mains_open_reg <= 1'b0;
    end else begin
      bars_reg <= (st_next == sltc_pkg::XS_GEN);
      mains_open_reg <= mts_assigned && (st_next != sltc_pkg::XS_MAINS);
    end
  end
  assign BARS_SWITCH_CLOSE_O = bars_reg;
  assign MAINS_SWITCH_OPEN_O = mains_open_reg;

  AST_PARALLEL_BLOCK: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    mains_parallel |-> !GEN_BRK_CLOSE_O)
    else $error("breaker close allowed while mains paralleled");
  AST_TEST_REQ: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (mode == sltc_pkg::MODE_TEST) |-> INTERVENTION_REQ_O)
    else $error("test mode without intervention request");
  AST_AUTO_REQ: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (mode == sltc_pkg::MODE_AUTO && start_inh && !remote_run && !keep_req) |-> !INTERVENTION_REQ_O)
    else $error("auto intervention despite start inhibit");
  AST_NO_GTS: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (!gts_assigned && st_reg == sltc_pkg::XS_MAINS) |=> !BARS_SWITCH_CLOSE_O)
    else $error("transfer without generators switch output");
  AST_BREAK_BEFORE: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    $rose(BARS_SWITCH_CLOSE_O) && mts_assigned |-> MAINS_SWITCH_OPEN_O && $past(MAINS_SWITCH_OPEN_O))
    else $error("generators switch closed before mains switch opened");
  AST_STOPPED: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (!any_run && st_reg == sltc_pkg::XS_MAINS) [*2] |-> !BARS_SWITCH_CLOSE_O && !MAINS_SWITCH_OPEN_O)
    else $error("switches not at mains with all generators stopped");
  AST_LEAVE_ORDER: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (st_reg == sltc_pkg::XS_DROP) |-> !BARS_SWITCH_CLOSE_O)
    else $error("generators switch still closed while leaving");
  AST_WARN: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (want_open && att_reg == ATT_MAX) |=> BREAKER_OPEN_FAIL_WARNING_O)
    else $error("open failure warning not raised");
  AST_MODE_MAINS: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (mode == sltc_pkg::MODE_MAN && !remote_run) [*3] |-> st_reg != sltc_pkg::XS_GEN || leave)
    else $error("transfer to generators outside automatic mode");
endmodule : sltc_core

/* core/sltc_timer.sv */
// Millisecond tick divider and reloadable exchange timer
`timescale 1ns/100ps
module sltc_timer #(
  parameter int DIV = sltc_pkg::TICK_DIV
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  sltc_tmr_if.tmr tmr
);
  logic [15:0] div_reg;
  logic [sltc_pkg::MS_W-1:0] cnt_reg;
  wire div_end = (div_reg == 16'(DIV - 1));

  // Free-running divider gives a one-cycle millisecond enable
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) div_reg <= 16'h0000;
    else div_reg <= div_end ? 16'h0000 : div_reg + 16'h0001;
  end
  assign tmr.tick = div_end;

  // Reload on each load request, count down on ticks
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) cnt_reg <= '0;
    else if (tmr.load) cnt_reg <= tmr.count_ms;
    else if (div_end && cnt_reg != '0) cnt_reg <= cnt_reg - 1'b1;
  end
  assign tmr.done = (cnt_reg == '0) && !tmr.load;

  AST_TMR_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!tmr.load && !div_end && cnt_reg != '0) |=> $stable(cnt_reg))
    else $error("exchange timer moved without a tick");
endmodule : sltc_timer

/* testbench/sltc_partner.sv */
// Breaker and peer controller model facing one generator controller
`timescale 1ns/100ps
module sltc_partner (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Breaker command and scenario knobs
  input wire logic brk_cmd_i,
  input wire logic stuck_i,
  input wire logic peer_open_i,
  input wire logic [15:0] peer_pwr_i,
  input wire logic [15:0] own_pwr_i,
  // Feedback to the controller
  output logic brk_closed_o,
  output logic [15:0] closed_pwr_o,
  output logic no_open_o
);
  logic [1:0] lag_reg;
  // Breaker answers two cycles late; a stuck one stays closed like a welded contact
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lag_reg <= 2'h0;
    end else begin
      lag_reg <= {lag_reg[0], brk_cmd_i | (stuck_i & lag_reg[1])};
    end
  end
  // Peers report summed rated power of closed breakers and whether any stays open
  assign brk_closed_o = lag_reg[1];
  assign closed_pwr_o = peer_pwr_i + (lag_reg[1] ? own_pwr_i : 16'h0000);
  assign no_open_o = lag_reg[1] & ~peer_open_i;
endmodule : sltc_partner

/* testbench/standby_load_transfer_control_test.sv */
// Self-checking bench for the standby load transfer control block
`timescale 1ns/100ps
module standby_load_transfer_control_test;
  localparam int DIV = 10;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic mains_c = 1'b0, ltb_c = 1'b0, ltb_p = 1'b1, remote = 1'b0, keep = 1'b0, tload = 1'b1;
  logic generators_transfer_switch = 1'b0, mains_transfer_switch = 1'b1, tol = 1'b1, icf = 1'b0, sinh = 1'b0, linh = 1'b0, shut = 1'b0;
  logic eng = 1'b0, anyg = 1'b0, ack = 1'b0, imm = 1'b0, dl_wr = 1'b0, db_wr = 1'b0, stuck = 1'b0;
  logic popen = 1'b1, wexp = 1'b0, brk_fb, no_open, send, start, intv, brk, warn, bars, mopen, afrc;
  logic [1:0] mode = sltc_pkg::MODE_AUTO;
  logic [15:0] dl = 16'h0000, db = 16'h0000, ppwr = 16'h0000, cpwr, demand;
  logic [15:0] exch = 16'h0002, mdel = 16'h0003;
  int miscompares = 0, checked = 0, cycles = 0, n, k;
  // 50 MHz system clock
  always #10 clk = ~clk;
  // Hang guard; the full run needs only a few thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  // Short tick divider and attempt time keep the run brief
  sltc_core #(.DIV(DIV), .ATTEMPT_MS(2)) uut (.CLK_SYS_I(clk), .RST_N_I(rst_n),
    .GEN_BRK_CLOSED_I(brk_fb), .MAINS_BRK_CLOSED_I(mains_c), .LTB_BRK_CLOSED_I(ltb_c),
    .LTB_BRK_PRESENT_I(ltb_p), .MODE_I(mode), .REMOTE_RUN_I(remote), .KEEP_SUPPLY_I(keep),
    .TEST_LOAD_I(tload), .GTS_ASSIGNED_I(generators_transfer_switch), .MTS_ASSIGNED_I(mains_transfer_switch), .EXCHANGE_MS_I(exch),
    .MAINS_DELAY_MS_I(mdel), .MAINS_IN_TOL_I(tol), .INHIBIT_CONTACT_FAIL_I(icf), .START_INHIBIT_I(sinh),
    .LOAD_INHIBIT_I(linh), .SHUTDOWN_I(shut), .ENGINE_RUNNING_I(eng), .ANY_GEN_RUNNING_I(anyg),
    .WARN_ACK_I(ack), .IMMEDIATE_SUPPLY_I(imm), .CLOSED_RATED_PWR_I(cpwr), .NO_OPEN_AVAIL_I(no_open),
    .DEMAND_LOCAL_I(dl), .DEMAND_LOCAL_WR_I(dl_wr), .DEMAND_BUS_I(db), .DEMAND_BUS_WR_I(db_wr),
    .DEMAND_O(demand), .DEMAND_BUS_SEND_O(send), .START_REQ_O(start), .INTERVENTION_REQ_O(intv),
    .GEN_BRK_CLOSE_O(brk), .BREAKER_OPEN_FAIL_WARNING_O(warn), .BARS_SWITCH_CLOSE_O(bars),
    .MAINS_SWITCH_OPEN_O(mopen), .AUTO_FORCED_O(afrc));
  // Switchgear and peers
  sltc_partner partner (.clk_i(clk), .rst_n_i(rst_n), .brk_cmd_i(brk), .stuck_i(stuck),
    .peer_open_i(popen), .peer_pwr_i(ppwr), .own_pwr_i(16'h003C), .brk_closed_o(brk_fb),
    .closed_pwr_o(cpwr), .no_open_o(no_open));
  // Reference model of the breaker permission
  function automatic logic exp_brk();
    logic par;
    par = mains_c && (ltb_c || !ltb_p);
    return eng && !shut && !linh && !(mode == sltc_pkg::MODE_TEST && !tload) && !par;
  endfunction : exp_brk
  // Reference model of the intervention request
  function automatic logic exp_int();
    return remote || mode == sltc_pkg::MODE_TEST || (mode == sltc_pkg::MODE_AUTO && !sinh && !tol)
      || (keep && wexp && !shut);
  endfunction : exp_int
  function automatic logic out(int i);
    case (i)
      0: return bars;
      1: return mopen;
      2: return start;
      3: return warn;
      default: return afrc;
    endcase
  endfunction : out
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wt(int c);
    repeat (c) @(negedge clk);
  endtask : wt
  // Bounded wait for an output level, then compare it
  task automatic wchk(string what, int i, logic v, int lim);
    n = 0;
    while (out(i) !== v && n < lim) begin
      wt(1);
      n++;
    end
    chk(what, {15'h0000, out(i)}, {15'h0000, v});
  endtask : wchk
  task automatic win(string what, int lo, int hi);
    chk(what, {15'h0000, n >= lo && n <= hi}, 16'h0001);
  endtask : win
  // One-cycle demand write, counting bus echo pulses
  task automatic wr(logic bus, logic [15:0] v);
    dl = v;
    db = v;
    dl_wr = !bus;
    db_wr = bus;
    k = 0;
    wt(1);
    k += int'(send === 1'b1);
    dl_wr = 1'b0;
    db_wr = 1'b0;
    repeat (4) begin
      wt(1);
      k += int'(send === 1'b1);
    end
  endtask : wr
  task automatic done(string name);
    $display("test %s finished", name);
  endtask : done
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  initial begin
    n = $urandom(32'h0000_9a38);
    wt(5);
    rst_n = 1'b1;
    wt(3);
    chk("demand_rst", demand, 16'h0000);
    wr(1'b0, 16'h004D);
    chk("send_local", k[15:0], 16'h0001);
    wr(1'b1, 16'h0064);
    chk("send_bus", k[15:0], 16'h0000);
    chk("demand", demand, 16'h0064);
    done("demand");
    tol = 1'b0;
    wchk("start_set", 2, 1'b1, 60);
    win("start_delay", 20, 36);
    tol = 1'b1;
    wchk("start_clr", 2, 1'b0, 60);
    win("stop_delay", 20, 36);
    tol = 1'b0;
    eng = 1'b1;
    anyg = 1'b1;
    wt(40);
    done("mains_delay");
    for (int i = 0; i < 24; i++) begin
      {shut, linh, mains_c, ltb_c, ltb_p} = 5'($urandom);
      remote = 1'b1;
      wt(4);
      chk("brk_close", {15'h0000, brk}, {15'h0000, exp_brk()});
      chk("intv_remote", {15'h0000, intv}, 16'h0001);
    end
    {shut, linh, mains_c, ltb_c, ltb_p} = 5'h01;
    tol = 1'b1;
    wchk("start_clr2", 2, 1'b0, 60);
    mode = sltc_pkg::MODE_TEST;
    remote = 1'b0;
    tol = 1'b1;
    sinh = 1'b1;
    tload = 1'b0;
    wt(4);
    chk("brk_test0", {15'h0000, brk}, {15'h0000, exp_brk()});
    chk("intv_test", {15'h0000, intv}, 16'h0001);
    done("breaker");
    for (int i = 0; i < 24; i++) begin
      mode = 2'($urandom % 3);
      {sinh, tol} = 2'($urandom);
      wt(40);
      chk("intv", {15'h0000, intv}, {15'h0000, exp_int()});
    end
    {mode, tol, sinh, generators_transfer_switch, tload} = {sltc_pkg::MODE_AUTO, 4'h3};
    wt(30);
    chk("no_xfer_low_pwr", {15'h0000, bars | mopen}, 16'h0000);
    ppwr = 16'h0032;
    wchk("mains_open", 1, 1'b1, 20);
    chk("bars_after", {15'h0000, bars}, 16'h0000);
    wchk("bars_close", 0, 1'b1, 40);
    win("exchange", 9, 24);
    linh = 1'b1;
    wchk("bars_drop", 0, 1'b0, 10);
    chk("mains_held", {15'h0000, mopen}, 16'h0001);
    wchk("mains_back", 1, 1'b0, 60);
    chk("brk_opened", {15'h0000, brk_fb}, 16'h0000);
    {linh, ppwr, popen} = 18'h00000;
    wchk("no_open_avail", 0, 1'b1, 80);
    done("transfer");
    mode = sltc_pkg::MODE_MAN;
    wchk("man_bars", 0, 1'b0, 10);
    wchk("man_mains", 1, 1'b0, 60);
    {mode, remote} = {sltc_pkg::MODE_OFF, 1'b1};
    wchk("remote_xfer", 0, 1'b1, 80);
    tol = 1'b1;
    wchk("remote_ok", 0, 1'b0, 50);
    {mode, remote, tol, generators_transfer_switch} = {sltc_pkg::MODE_AUTO, 3'h0};
    wt(80);
    chk("gts_unassigned", {15'h0000, bars}, 16'h0000);
    {generators_transfer_switch, popen, imm} = 3'h7;
    wchk("immediate", 0, 1'b1, 80);
    mode = sltc_pkg::MODE_MAN;
    wt(60);
    mode = sltc_pkg::MODE_TEST;
    wchk("auto_forced", 4, 1'b1, 10);
    wchk("test_xfer", 0, 1'b1, 80);
    done("modes");
    {mode, remote, keep, stuck} = {sltc_pkg::MODE_AUTO, 3'h7};
    wt(10);
    linh = 1'b1;
    wchk("open_fail", 3, 1'b1, 90);
    win("open_attempts", 50, 75);
    {remote, tol, wexp} = 3'h3;
    wt(4);
    chk("warn_intv", {15'h0000, intv}, {15'h0000, exp_int()});
    {stuck, ack} = 2'h1;
    wt(4);
    {ack, wexp} = 2'h0;
    wt(40);
    chk("warn_ack", {15'h0000, warn}, 16'h0000);
    chk("intv_ack", {15'h0000, intv}, {15'h0000, exp_int()});
    done("open_fail");
    complete_run();
  end
endmodule : standby_load_transfer_control_test
